// ==== hdl/usrx_receiver.sv ====
/*
 * Asynchronous serial receive path with 16x/8x oversampling, majority
 * voting, parity and stop checks, a two-entry buffer, and the SPI pin
 * role outputs. Assumes sample_tick_i is a one-cycle pulse from the baud
 * generator on clk_sys_i at the oversampling rate.
 */
// Functional notes
// RULE1: Receiver runs only while the receiver enable bit is set.
// RULE2: Frame starts only on a valid low start bit; bits shift in.
// RULE3: Only the first stop bit is used; then search for start again.
// RULE4: At the first stop bit the frame moves into the buffer.
// RULE5: With nine data bits, the ninth goes to the ninth-bit position.
// RULE6: Software reads ninth bit and error flags before the data.
// RULE7: Buffer holds two entries, each with its own error flags.
// RULE8: Receive complete is high exactly while the buffer holds data; the registered flag trails the buffer by one cycle.
// RULE9: Interrupt follows receive complete when both enables are set.
// RULE10: Disable stops at once, flushes buffer, releases the pin.
// RULE11: Framing error is 0 for a high stop bit, 1 for low.
// RULE12: Full buffer plus a new frame sets overrun; frame is lost.
// RULE13: Reading the buffer frees room and clears overrun.
// RULE14: With parity on, a parity mismatch marks a parity error.
// RULE15: Parity error reads zero while parity is disabled.
// RULE16: Oversample 16x normally, 8x in double speed.
// RULE17: Start validated by samples 8-10 or 4-6; then resync.
// RULE18: Resynchronisation happens at every start bit.
// RULE19: Data and parity bits use the same three-sample majority.
// RULE20: Stop bit accepted by two of three high; then idle.
// RULE21: In SPI, select pin is slave input or master output.
// RULE22: In SPI the input pin is MISO and the output pin MOSI.
// RULE23: Mode field: 00 UART, 01 synchronous, 11 SPI, 10 reserved.
// RULE24: Double speed select applies in UART mode only.
// RULE25: Reading data pops the oldest entry and updates the flags.
`timescale 1ns/1ps
`default_nettype none

module usrx_receiver
	import usrx_pkg::*;
(
	input wire logic clk_sys_i,              // System clock, 40 MHz
	input wire logic rst_i,                  // Async reset, high
	input wire usrx_pkg::usrx_cfg_s cfg_i,   // Control register bits
	input wire logic sample_tick_i,          // Oversampling tick
	input wire logic rx_pin_i,               // Serial input pin
	input wire logic ss_n_pin_i,             // Select pin input level
	input wire logic ss_level_i,             // Select level to drive
	input wire logic data_read_i,            // Data register read pulse
	output usrx_pkg::usrx_stat_s stat_o,     // Status and oldest entry
	output logic rx_irq_o,                   // Receive done request
	output logic rx_pin_claimed_o,           // Input pin in use
	output logic miso_role_o,                // Input pin acts as MISO
	output logic mosi_role_o,                // Output pin acts as MOSI
	output logic ss_selected_o,              // Slave selected, SPI
	output logic ss_out_o,                   // Select pin output value
	output logic ss_oe_n_o                   // Select pin enable, low
);
	import usrx_pkg::*;

	// Majority of three samples
	function automatic logic maj3(input logic a, input logic b,
		input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction : maj3

	// Index of the last data bit for a length code
	function automatic logic [3:0] last_bit(input logic [2:0] len);
		case (len)
			USRX_LEN_5: last_bit = 4'h4;
			USRX_LEN_6: last_bit = 4'h5;
			USRX_LEN_7: last_bit = 4'h6;
			USRX_LEN_9: last_bit = 4'h8;
			default: last_bit = 4'h7;
		endcase
	endfunction : last_bit

	// Mask of valid data bits for a length code
	function automatic logic [8:0] bit_mask(input logic [2:0] len);
		bit_mask = 9'h1FF >> (4'h8 - last_bit(len));
	endfunction : bit_mask

	logic rx_meta, rx_s, rx_prev, ss_meta, ss_s;
	usrx_state_e state;
	logic [3:0] smp_cnt, bit_idx;
	logic [1:0] votes;
	logic [8:0] shreg;
	logic par_err, overrun;
	logic run, dbl, vote, decide, bit_end, frame_done, store, pop;
	logic [3:0] lo, hi, last;
	logic [1:0] buf_count;
	logic buf_full, par_on;
	usrx_entry_s head, new_entry;

	// Double speed only counts in UART mode
	assign run = cfg_i.enable && cfg_i.mode == USRX_MODE_UART; // see RULE1
	assign dbl = cfg_i.dbl && cfg_i.mode == USRX_MODE_UART; // see RULE24
	assign lo = dbl ? USRX_D_LO : USRX_N_LO; // see RULE16
	assign hi = dbl ? USRX_D_HI : USRX_N_HI;
	assign last = dbl ? USRX_D_LAST : USRX_N_LAST;
	assign par_on = cfg_i.par[USRX_PAR_EN_BIT];

	// Vote of samples lo, lo+1 and the current one at hi
	assign vote = maj3(votes[1], votes[0], rx_s); // see RULE19
	assign decide = sample_tick_i && smp_cnt == hi && state != USRX_IDLE;
	assign bit_end = sample_tick_i && smp_cnt == last;
	assign frame_done = decide && state == USRX_STOP; // see RULE4
	assign buf_full = buf_count == USRX_DEPTH;
	assign pop = data_read_i && buf_count != 2'h0; // see RULE25
	// A read in the same cycle makes room for the frame
	assign store = frame_done && (!buf_full || pop); // see RULE12

	// Two-flop synchronisers for the pins
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_meta <= 1'b1;
			rx_s <= 1'b1;
			ss_meta <= 1'b1;
			ss_s <= 1'b1;
		end
		else
		begin
			rx_meta <= rx_pin_i;
			rx_s <= rx_meta;
			ss_meta <= ss_n_pin_i;
			ss_s <= ss_meta;
		end
	end

	// Line level at the previous tick, for edge search
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			rx_prev <= 1'b1;
		else if (!run)
			rx_prev <= 1'b1;
		else if (sample_tick_i)
			rx_prev <= rx_s;
	end

	// Frame sequencer; disable drops any frame in flight
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			state <= USRX_IDLE;
		else if (!run)
			state <= USRX_IDLE; // see RULE10
		else
		begin
			case (state)
				USRX_IDLE:
					if (sample_tick_i && rx_prev && !rx_s)
						state <= USRX_START; // see RULE2
				USRX_START:
					if (decide)
						state <= vote ? USRX_IDLE : USRX_DATA; // see RULE17
				USRX_DATA:
					if (decide && bit_idx == last_bit(cfg_i.len))
						state <= par_on ? USRX_PARITY : USRX_STOP;
				USRX_PARITY:
					if (decide)
						state <= USRX_STOP;
				USRX_STOP:
					if (decide)
						state <= USRX_IDLE; // see RULE3
				default:
					state <= USRX_IDLE;
			endcase
		end
	end

	// Sample counter restarts at every falling edge found in idle;
	// the edge tick itself was sample one, so the next tick is two
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			smp_cnt <= USRX_FIRST_SAMPLE;
		else if (state == USRX_IDLE)
			smp_cnt <= USRX_FIRST_SAMPLE + 4'h1; // see RULE18
		else if (bit_end)
			smp_cnt <= USRX_FIRST_SAMPLE;
		else if (sample_tick_i)
			smp_cnt <= smp_cnt + 4'h1;
	end

	// The two early centre samples
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			votes <= 2'h3;
		else if (sample_tick_i && smp_cnt >= lo && smp_cnt < hi)
			votes <= {votes[0], rx_s};
	end

	// Data bits shift in LSB first, in arrival order
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			shreg <= 9'h000;
			bit_idx <= 4'h0;
		end
		else if (state == USRX_START)
		begin
			shreg <= 9'h000;
			bit_idx <= 4'h0;
		end
		else if (decide && state == USRX_DATA)
		begin
			shreg[bit_idx] <= vote; // see RULE19
			bit_idx <= bit_idx + 4'h1;
		end
	end

	// Parity check: odd selection inverts the expected value
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			par_err <= 1'b0;
		else if (state == USRX_START)
			par_err <= 1'b0;
		else if (decide && state == USRX_PARITY)
			par_err <= (^(shreg & bit_mask(cfg_i.len))) ^
				cfg_i.par[USRX_PAR_ODD_BIT] ^ vote; // see RULE14
	end

	// Entry as stored; flags travel with their data
	always_comb
	begin
		new_entry.data = shreg[7:0];
		new_entry.ninth = (cfg_i.len == USRX_LEN_9) &&
			shreg[USRX_NINTH_POS]; // see RULE5
		new_entry.fe = !vote; // see RULE11, RULE20
		new_entry.pe = par_on && par_err; // see RULE15
	end

	// Overrun: set on a loss, cleared by a read; a read never coincides with a loss
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			overrun <= 1'b0;
		else if (!run)
			overrun <= 1'b0;
		else if (frame_done && !store)
			overrun <= 1'b1; // see RULE12
		else if (pop)
			overrun <= 1'b0; // see RULE13
	end

	usrx_rxbuf u_buf (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.flush_i(!cfg_i.enable),
		.push_i(store),
		.entry_i(new_entry),
		.pop_i(pop),
		.head_o(head),
		.count_o(buf_count)
	); // see RULE7

	// Registered status; trails the buffer by one cycle
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stat_o <= '0;
			rx_irq_o <= 1'b0;
		end
		else
		begin
			stat_o.receive_complete_flag <= buf_count != 2'h0; // see RULE8
			stat_o.overrun_flag <= overrun;
			stat_o.head <= head;
			stat_o.head.pe <= head.pe && par_on; // see RULE15
			rx_irq_o <= buf_count != 2'h0 && cfg_i.irq_en &&
				cfg_i.gie; // see RULE9
		end
	end

	// Pin roles; the reserved mode claims nothing special
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_pin_claimed_o <= 1'b0;
			miso_role_o <= 1'b0;
			mosi_role_o <= 1'b0;
			ss_selected_o <= 1'b0;
			ss_out_o <= 1'b1;
			ss_oe_n_o <= 1'b1;
		end
		else
		begin
			rx_pin_claimed_o <= cfg_i.enable; // see RULE10
			miso_role_o <= cfg_i.mode == USRX_MODE_SPI; // see RULE22, RULE23
			mosi_role_o <= cfg_i.mode == USRX_MODE_SPI;
			ss_selected_o <= cfg_i.mode == USRX_MODE_SPI &&
				!cfg_i.master && !ss_s; // see RULE21
			ss_out_o <= ss_level_i;
			ss_oe_n_o <= !(cfg_i.mode == USRX_MODE_SPI && cfg_i.master &&
				!cfg_i.ss_ctrl); // see RULE21
		end
	end

	// Checks
	busy_needs_run_a: assert property (@(posedge clk_sys_i) // see RULE1
		disable iff (rst_i) state != USRX_IDLE |-> $past(run))
		else $error("receiver busy while disabled");

	start_reject_a: assert property (@(posedge clk_sys_i) // see RULE17
		disable iff (rst_i) (state == USRX_START && decide && vote && run)
		|=> state == USRX_IDLE)
		else $error("high start bit not rejected");

	stop_store_a: assert property (@(posedge clk_sys_i) // see RULE4
		disable iff (rst_i) (frame_done && !buf_full && run)
		|=> buf_count == $past(buf_count) + 2'h1 - {1'b0, $past(pop)})
		else $error("finished frame not stored");

	fe_vote_a: assert property (@(posedge clk_sys_i) // see RULE20
		disable iff (rst_i) (store && buf_count == 2'h0)
		|=> head.fe != $past(vote))
		else $error("framing flag does not match stop vote");

	rxc_level_a: assert property (@(posedge clk_sys_i) // see RULE8
		disable iff (rst_i) stat_o.receive_complete_flag == ($past(buf_count) != 2'h0))
		else $error("receive complete does not track buffer");

	irq_gate_a: assert property (@(posedge clk_sys_i) // see RULE9
		disable iff (rst_i) rx_irq_o |-> stat_o.receive_complete_flag &&
		$past(cfg_i.irq_en) && $past(cfg_i.gie))
		else $error("interrupt without cause");

	disable_flush_a: assert property (@(posedge clk_sys_i) // see RULE10
		disable iff (rst_i) !cfg_i.enable |=> buf_count == 2'h0 ##1
		!stat_o.receive_complete_flag)
		else $error("disable did not flush buffer");

	overrun_set_a: assert property (@(posedge clk_sys_i) // see RULE12
		disable iff (rst_i) (frame_done && buf_full && !pop && run)
		|=> overrun && buf_count == USRX_DEPTH)
		else $error("overrun not flagged");

	pe_off_a: assert property (@(posedge clk_sys_i) // see RULE15
		disable iff (rst_i) (!par_on && !$past(par_on)) |-> !stat_o.head.pe)
		else $error("parity error while parity is off");

endmodule : usrx_receiver

`default_nettype wire

// ==== hdl/usrx_pkg.sv ====
/*
 * Shared types and constants of the serial receive path: mode codes,
 * frame options, oversampling points and the buffer entry layout.
 * Assumes nothing of its surroundings; compiled before all users.
 */
package usrx_pkg;

	// Operating mode field codes
	localparam logic [1:0] USRX_MODE_UART = 2'h0;
	localparam logic [1:0] USRX_MODE_SYNC = 2'h1;
	localparam logic [1:0] USRX_MODE_RSVD = 2'h2;
	localparam logic [1:0] USRX_MODE_SPI = 2'h3;

	// Character length field codes
	localparam logic [2:0] USRX_LEN_5 = 3'h0;
	localparam logic [2:0] USRX_LEN_6 = 3'h1;
	localparam logic [2:0] USRX_LEN_7 = 3'h2;
	localparam logic [2:0] USRX_LEN_8 = 3'h3;
	localparam logic [2:0] USRX_LEN_9 = 3'h7;

	// Parity mode field: upper bit enables, lower bit selects odd
	localparam int USRX_PAR_EN_BIT = 1;
	localparam int USRX_PAR_ODD_BIT = 0;

	// Oversampling points, normal (16x) and double speed (8x)
	localparam logic [3:0] USRX_N_LO = 4'h8;
	localparam logic [3:0] USRX_N_HI = 4'hA;
	localparam logic [3:0] USRX_N_LAST = 4'h0;
	localparam logic [3:0] USRX_D_LO = 4'h4;
	localparam logic [3:0] USRX_D_HI = 4'h6;
	localparam logic [3:0] USRX_D_LAST = 4'h8;
	localparam logic [3:0] USRX_FIRST_SAMPLE = 4'h1;

	// Buffer depth and bit positions
	localparam logic [1:0] USRX_DEPTH = 2'h2;
	localparam int USRX_NINTH_POS = 8;

	// Configuration bits from the control registers
	typedef struct packed {
		logic enable;      // receiver enable bit
		logic dbl;         // double speed select
		logic [1:0] mode;  // operating mode field
		logic [2:0] len;   // char length field
		logic [1:0] par;   // parity mode field
		logic irq_en;      // receive done irq enable
		logic gie;         // global interrupt enable
		logic master;      // master mode in SPI
		logic ss_ctrl;     // select pin control bit
	} usrx_cfg_s;

	// One receive buffer entry
	typedef struct packed {
		logic ninth;
		logic fe;
		logic pe;
		logic [7:0] data;
	} usrx_entry_s;

	// Status seen by software, oldest unread entry
	typedef struct packed {
		logic receive_complete_flag;
		logic overrun_flag;
		usrx_entry_s head;
	} usrx_stat_s;

	typedef enum logic [2:0] {
		USRX_IDLE = 3'b000,
		USRX_START = 3'b001,
		USRX_DATA = 3'b010,
		USRX_PARITY = 3'b011,
		USRX_STOP = 3'b100
	} usrx_state_e;

endpackage : usrx_pkg

// ==== hdl/usrx_rxbuf.sv ====
/*
 * Two-entry receive buffer. Slot zero is always the oldest entry so the
 * head is a plain register. Assumes the caller pushes only when there is
 * room or a pop happens in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module usrx_rxbuf
	import usrx_pkg::*;
(
	input wire logic clk_sys_i,             // System clock
	input wire logic rst_i,                 // Async reset, high
	input wire logic flush_i,               // Drop all entries
	input wire logic push_i,                // Store entry_i
	input wire usrx_pkg::usrx_entry_s entry_i, // New entry
	input wire logic pop_i,                 // Drop oldest entry
	output usrx_pkg::usrx_entry_s head_o,   // Oldest entry
	output logic [1:0] count_o              // Entries held
);
	import usrx_pkg::*;

	usrx_entry_s slot [0:1];

	assign head_o = slot[0];

	// Occupancy; a pop on an empty buffer is ignored
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			count_o <= 2'h0;
		else if (flush_i)
			count_o <= 2'h0;
		else if (push_i && !(pop_i && count_o != 2'h0))
			count_o <= count_o + 2'h1;
		else if (pop_i && !push_i && count_o != 2'h0)
			count_o <= count_o - 2'h1;
	end

	// Slot moves; flushed data is cleared as well
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			slot[0] <= '0;
			slot[1] <= '0;
		end
		else if (flush_i)
		begin
			slot[0] <= '0;
			slot[1] <= '0;
		end
		else if (pop_i && count_o != 2'h0)
		begin
			if (push_i && count_o == 2'h1)
				slot[0] <= entry_i;
			else
				slot[0] <= slot[1];
			if (push_i && count_o == USRX_DEPTH)
				slot[1] <= entry_i;
		end
		else if (push_i)
		begin
			if (count_o == 2'h0)
				slot[0] <= entry_i;
			else
				slot[1] <= entry_i;
		end
	end

endmodule : usrx_rxbuf

`default_nettype wire

// ==== tb/usrx_line_tx.sv ====
/*
 * Remote serial transmitter model: sends up to 32 line bits, first bit
 * first, each held for tpb_i oversampling ticks. Assumes tick_i is the
 * tick that feeds the receiver, so the bit timing stays exact.
 */
`timescale 1ns/1ps
`default_nettype none

module usrx_line_tx (
	input wire logic clk_sys_i,      // System clock
	input wire logic rst_i,          // Async reset, high
	input wire logic tick_i,         // Oversampling tick
	input wire logic go_i,           // Start sending frame_i
	input wire logic [31:0] frame_i, // Line bits, first at bit 0
	input wire logic [5:0] nbits_i,  // Bits to send
	input wire logic [4:0] tpb_i,    // Ticks per bit
	output logic line_o,             // Serial line
	output logic busy_o              // Bits still going out
);
	logic [31:0] sh;
	logic [5:0] left;
	logic [4:0] cnt;

	// Idle line is high, as the pull-up would hold it between frames
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			line_o <= 1'b1;
			busy_o <= 1'b0;
			sh <= '0;
			left <= '0;
			cnt <= '0;
		end
		else if (!busy_o && go_i)
		begin
			sh <= frame_i;
			left <= nbits_i;
			cnt <= '0;
			busy_o <= 1'b1;
			line_o <= frame_i[0];
		end
		else if (busy_o && tick_i)
		begin
			cnt <= cnt + 5'h1;
			if (cnt == tpb_i - 5'h1)
			begin
				cnt <= '0;
				sh <= sh >> 1;
				left <= left - 6'h1;
				line_o <= (left == 6'h1) ? 1'b1 : sh[1];
				busy_o <= (left != 6'h1);
			end
		end
	end
endmodule : usrx_line_tx
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * Self-checking bench of the serial receive path. Assumes the tick
 * comes every second clock and the transmitter model drives the line.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import usrx_pkg::*;
	logic clk_sys_i, rst_i, ss_n, ss_lvl, rd, go, line, busy;
	logic div = 1'b0;
	logic tick = 1'b0;
	logic irq, claimed, miso, mosi, sel, ss_out, ss_oe_n;
	usrx_cfg_s cfg, c;
	usrx_stat_s stat;
	logic [31:0] frame, seed, r;
	logic [5:0] nbits;
	logic [4:0] tpb;
	int failures, total_checks;
	usrx_entry_s q[$];
	logic [2:0] lens[5] = '{USRX_LEN_5, USRX_LEN_6, USRX_LEN_7, USRX_LEN_8,
		USRX_LEN_9};

	usrx_receiver i_usrx_receiver (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.cfg_i(cfg), .sample_tick_i(tick), .rx_pin_i(line),
		.ss_n_pin_i(ss_n), .ss_level_i(ss_lvl), .data_read_i(rd),
		.stat_o(stat), .rx_irq_o(irq), .rx_pin_claimed_o(claimed),
		.miso_role_o(miso), .mosi_role_o(mosi), .ss_selected_o(sel),
		.ss_out_o(ss_out), .ss_oe_n_o(ss_oe_n));
	usrx_line_tx i_usrx_line_tx (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.tick_i(tick), .go_i(go), .frame_i(frame), .nbits_i(nbits),
		.tpb_i(tpb), .line_o(line), .busy_o(busy));

	// Clock and a tick every second cycle, standing in for the baud unit
	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		div <= !div;
		tick <= div;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	function automatic int dlen();
		return (cfg.len == USRX_LEN_9) ? 9 : int'(cfg.len) + 5;
	endfunction : dlen

	// Entry the receiver should store; perr flips the sent parity bit
	function automatic usrx_entry_s expect_of(logic [8:0] d, logic perr,
		logic stop);
		usrx_entry_s e;
		e = '0;
		for (int i = 0; i < dlen() && i < 8; i++)
			e.data[i] = d[i];
		e.ninth = (dlen() == 9) & d[8];
		e.fe = !stop;
		e.pe = cfg.par[USRX_PAR_EN_BIT] & perr;
		return e;
	endfunction : expect_of

	// Append one frame, LSB first, in the current format
	task automatic add(input logic [8:0] d, input logic perr,
		input logic stop);
		logic p;
		int k;
		p = cfg.par[USRX_PAR_ODD_BIT] ^ perr;
		frame[nbits] = 1'b0;
		for (int i = 0; i < dlen(); i++)
		begin
			frame[nbits + 1 + i] = d[i];
			p ^= d[i];
		end
		k = nbits + 1 + dlen();
		if (cfg.par[USRX_PAR_EN_BIT])
			frame[k++] = p;
		frame[k] = stop;
		nbits = 6'(k + 1);
		if (cfg.enable && cfg.mode == USRX_MODE_UART)
			q.push_back(expect_of(d, perr, stop));
	endtask : add

	// Send what was built; the wait is bounded by the longest burst
	task automatic fire();
		int w;
		@(posedge clk_sys_i) go <= 1'b1;
		@(posedge clk_sys_i) go <= 1'b0;
		// Busy is only visible one edge after go is taken
		@(posedge clk_sys_i);
		for (w = 0; busy !== 1'b0 && w < 3000; w++)
			@(posedge clk_sys_i);
		check(w < 3000, 1);
		repeat (4) @(posedge clk_sys_i);
		nbits = '0;
		frame = '1;
	endtask : fire

	// Flags and ninth bit are read before the data read pops the entry
	task automatic pop_check();
		usrx_entry_s e;
		e = q.pop_front();
		check(stat.receive_complete_flag, 1);
		check(stat.head, e);
		check(irq, cfg.irq_en & cfg.gie);
		check(claimed, 1);
		@(posedge clk_sys_i) rd <= 1'b1;
		@(posedge clk_sys_i) rd <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask : pop_check

	// Registered role outputs follow the new setting one edge later
	task automatic set_cfg();
		@(posedge clk_sys_i) cfg <= c;
		repeat (2) @(posedge clk_sys_i);
	endtask : set_cfg

	initial
	begin
		cfg = '0;
		ss_n = 1'b1;
		ss_lvl = 1'b0;
		rd = 1'b0;
		go = 1'b0;
		frame = '1;
		nbits = '0;
		tpb = 5'h10;
		seed = 32'h6B52;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		c = '0;
		c.enable = 1'b1;
		// Every length and parity mode, in both sampling rates
		for (int s = 0; s < 2; s++)
			for (int l = 0; l < 5; l++)
				for (int p = 0; p < 3; p++)
				begin
					r = rnd();
					c.dbl = s[0];
					c.len = lens[l];
					c.par = (p == 0) ? 2'h0 : {1'b1, p[1]};
					c.irq_en = r[13];
					c.gie = r[14];
					set_cfg();
					tpb = s[0] ? 5'h08 : 5'h10;
					add(r[8:0], r[9] & r[10], r[11] | r[12]);
					fire();
					pop_check();
					check(stat.receive_complete_flag, 0);
				end
		// Back to back, second stop bit on the first frame ignored
		c.len = USRX_LEN_8;
		c.par = 2'h0;
		c.dbl = 1'b0;
		set_cfg();
		tpb = 5'h10;
		add(9'h0A5, 0, 1);
		frame[nbits] = 1'b1;
		nbits++;
		add(9'h03C, 0, 1);
		fire();
		pop_check();
		pop_check();
		// Third frame into a full buffer is lost
		add(9'h011, 0, 1);
		add(9'h022, 0, 1);
		add(9'h033, 0, 1);
		void'(q.pop_back());
		fire();
		check(stat.overrun_flag, 1);
		pop_check();
		check(stat.overrun_flag, 0);
		add(9'h044, 0, 1);
		fire();
		pop_check();
		pop_check();
		// Short low glitch is no start bit
		tpb = 5'h03;
		frame[0] = 1'b0;
		nbits = 6'h01;
		fire();
		// Long enough for a wrongly accepted start to finish a frame
		repeat (400) @(posedge clk_sys_i);
		check(stat.receive_complete_flag, 0);
		tpb = 5'h10;
		// Frames while disabled or outside UART mode are ignored
		for (int m = 0; m < 4; m++)
		begin
			c.enable = (m != 0);
			c.mode = 2'(m);
			set_cfg();
			check(claimed, c.enable);
			add(9'h0F0, 0, 1);
			fire();
			check(stat.receive_complete_flag, 0);
		end
		// Disable flushes a held entry at once
		c.enable = 1'b1;
		c.mode = USRX_MODE_UART;
		set_cfg();
		add(9'h07E, 0, 1);
		fire();
		check(stat.receive_complete_flag, 1);
		c.enable = 1'b0;
		set_cfg();
		repeat (2) @(posedge clk_sys_i);
		check(stat.receive_complete_flag, 0);
		q.delete();
		// Select pin and pin roles in SPI mode
		for (int i = 0; i < 8; i++)
		begin
			r = rnd();
			c.mode = USRX_MODE_SPI;
			c.master = i[0];
			c.ss_ctrl = i[1];
			@(posedge clk_sys_i)
			begin
				ss_n <= i[2];
				ss_lvl <= r[0];
			end
			set_cfg();
			repeat (4) @(posedge clk_sys_i);
			check({miso, mosi}, 2'h3);
			check(ss_oe_n, !(i[0] && !i[1]));
			check(sel, !i[0] && !i[2]);
			check(ss_out, r[0]);
		end
		complete_run();
	end

	// About 12k cycles of traffic expected; this limit leaves ample margin
	initial
	begin
		#(25 * 100000);
		failures++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
